// ### pkg/pcfgl_pkg.sv
// Shared constants for the PCI configuration bitstream loader
package pcfgl_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CSR_OFFSET = 8'h40;
  localparam logic [7:0] DATA_OFFSET = 8'h44;
  // ----------------------------------------
  // Control-status field positions
  // ----------------------------------------
  localparam int BIT_ACCESS_OK = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_INIT_N = 2;
  localparam int BIT_DATA_VALID = 3;
  localparam int BIT_SR_EMPTY = 4;
  localparam int BIT_SR_FULL = 5;
  localparam int BIT_PROGRAM_N = 8;
  localparam int BIT_LOAD_EN = 9;
  localparam int BIT_READBACK_N = 10;
  // ----------------------------------------
  // Reset value and write mask
  // ----------------------------------------
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [15:0] CSR_WMASK = 16'h0700;
  // ----------------------------------------
  // Timing and sizes
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYCLES = (INIT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 32;
  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  typedef enum logic [1:0] {SRC_NONE, SRC_STRAP, SRC_PCI, SRC_JTAG} pcfgl_src_t;
endpackage

// ### hw/pcfgl_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pcfgl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (ce_i && flush_i))
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ### hw/pcfgl_loader.sv
// Configuration loader behind the PCI configuration space registers
`timescale 1ns/1ps
// Overview of operation
// - Control-status at 40h, data word at 44h
// - Bit 1 reports configuration done
// - Bit 0 low during boundary-scan exchange
// - Load enable starts PCI-fed session
// - Full-word data write sets valid flag
// - FIFO push clears valid, sets empty
// - Readback bit low enters readback mode
// - Full flag marks readback word ready
// - PCI path accepted regardless of straps
// - Program pin > JTAG > PCI > strap
// - FIFO clocks from either fabric clock
// - PCI clock drives the fabric grid
module pcfgl_loader #(
  parameter int INIT_CYC = pcfgl_pkg::INIT_CYCLES,
  parameter int DEPTH = pcfgl_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Configuration space access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // Device pins and other configuration sources
  input wire logic program_pin_n_i,
  input wire logic jtag_busy_i,
  input wire logic strap_load_i,
  input wire logic [2:0] strap_mode_pins_i,
  // Configuration engine side
  output logic [31:0] engine_word_o,
  output logic engine_word_valid_o,
  input wire logic engine_word_ready_i,
  input wire logic engine_done_i,
  input wire logic engine_init_n_i,
  input wire logic [31:0] readback_word_i,
  input wire logic readback_valid_i,
  output logic readback_ready_o,
  // Clock selection for logic-side FIFO ports
  input wire logic quad_port_i,
  input wire logic master_clk_sel_i,
  input wire logic target_clk_sel_i,
  output logic master_clk_sel_o,
  output logic target_clk_sel_o,
  output logic pci_clk_to_grid_o,
  // Status
  output logic [1:0] source_o,
  output logic readback_mode_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      // Idle pin levels, so no false scan or strap after reset
      sync1 <= 4'h9;
      sync2 <= 4'h9;
    end
    else if (ce_i)
    begin
      sync1 <= {program_pin_n_i, jtag_busy_i, strap_load_i, engine_init_n_i};
      sync2 <= sync1;
    end
  end
  wire prog_pin_n = sync2[3];
  wire jtag_busy = sync2[2];
  wire strap_load = sync2[1];
  wire init_n_pin = sync2[0];
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic program_n;
  logic load_en;
  logic readback_n;
  logic data_valid;
  logic sr_empty;
  logic sr_full;
  logic [31:0] data_word;
  logic init_busy;
  logic [$clog2(INIT_CYC+1)-1:0] init_cnt;
  pcfgl_pkg::pcfgl_src_t src;
  pcfgl_pkg::pcfgl_src_t next_src;
  wire hit_csr = (cfg_addr_i[7:2] == pcfgl_pkg::CSR_OFFSET[7:2]);
  wire hit_data = (cfg_addr_i[7:2] == pcfgl_pkg::DATA_OFFSET[7:2]);
  wire csr_wr = ce_i && cfg_wr_i && hit_csr && cfg_be_i[1];
  wire data_wr = ce_i && cfg_wr_i && hit_data && (cfg_be_i == 4'hF);
  wire data_rd = ce_i && cfg_rd_i && hit_data;
  wire [15:0] csr_val = {5'h00, readback_n, load_en, program_n, 2'h0, sr_full, sr_empty,
                         data_valid, init_n_pin && !init_busy, engine_done_i, !jtag_busy};
  wire [31:0] rd_mux = hit_csr ? {16'h0000, csr_val} : (hit_data ? data_word : 32'h0000_0000);
  // ----------------------------------------
  // Source arbitration
  // ----------------------------------------
  // Priority arbitration
  wire prog_pulse = !prog_pin_n || !program_n;
  // Straps do not gate PCI path
  wire pci_req = load_en;
  always_comb
  begin
    next_src = pcfgl_pkg::SRC_NONE;
    if (prog_pulse)
      next_src = pcfgl_pkg::SRC_NONE;
    else if (jtag_busy)
      next_src = pcfgl_pkg::SRC_JTAG;
    else if (pci_req)
      next_src = pcfgl_pkg::SRC_PCI;
    else if (strap_load && (strap_mode_pins_i != 3'h7))
      next_src = pcfgl_pkg::SRC_STRAP;
  end
  wire pci_owns = (src == pcfgl_pkg::SRC_PCI);
  // ----------------------------------------
  // Data path and FIFO
  // ----------------------------------------
  logic [31:0] shift_reg;
  logic shift_full;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  // Held word moves toward shift stage
  wire push_word = data_valid && pci_owns && readback_n && fifo_in_ready && !init_busy;
  wire shift_load = fifo_out_valid && !shift_full;
  wire shift_take = shift_full && engine_word_ready_i;
  pcfgl_fifo #(
    .WIDTH(pcfgl_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .flush_i(prog_pulse),
    .in_valid_i(push_word),
    .in_ready_o(fifo_in_ready),
    .in_data_i(data_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!shift_full),
    .out_data_o(fifo_out_data)
  );
  // Readback capture
  // Take only on a real handshake, or the engine skips words
  wire rb_take = readback_ready_o && readback_valid_i && !sr_full;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      program_n <= 1'b1;
      load_en <= 1'b0;
      readback_n <= 1'b1;
    end
    else if (csr_wr)
    begin
      load_en <= cfg_wdata_i[pcfgl_pkg::BIT_LOAD_EN];
      program_n <= cfg_wdata_i[pcfgl_pkg::BIT_PROGRAM_N];
      readback_n <= cfg_wdata_i[pcfgl_pkg::BIT_READBACK_N];
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      src <= pcfgl_pkg::SRC_NONE;
    else if (ce_i)
      src <= next_src;
  end
  // Data valid: host write sets, transfer clears; a write wins
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (ce_i && prog_pulse))
      data_valid <= 1'b0;
    else if (data_wr)
      data_valid <= 1'b1;
    else if (ce_i && push_word)
      data_valid <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      data_word <= pcfgl_pkg::DATA_RESET;
    else if (data_wr)
      data_word <= cfg_wdata_i;
    else if (ce_i && rb_take)
      data_word <= readback_word_i;
  end
  // Empty flag set on transfer, cleared only by a new host word
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (ce_i && prog_pulse))
      sr_empty <= 1'b1;
    else if (ce_i && push_word)
      sr_empty <= 1'b1;
    else if (data_wr)
      sr_empty <= 1'b0;
  end
  // Full flag: readback capture sets, host read clears; capture wins
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (ce_i && (readback_n || prog_pulse)))
      sr_full <= 1'b0;
    else if (ce_i && rb_take)
      sr_full <= 1'b1;
    else if (data_rd)
      sr_full <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i || (ce_i && prog_pulse))
    begin
      shift_full <= 1'b0;
      shift_reg <= pcfgl_pkg::DATA_RESET;
    end
    else if (ce_i)
    begin
      if (shift_load)
      begin
        shift_reg <= fifo_out_data;
        shift_full <= 1'b1;
      end
      else if (shift_take)
        shift_full <= 1'b0;
    end
  end
  // Memory clear timer after the program pulse; init flag held low meanwhile
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      init_busy <= 1'b0;
      init_cnt <= '0;
    end
    else if (ce_i)
    begin
      if (prog_pulse)
      begin
        init_busy <= 1'b1;
        init_cnt <= '0;
      end
      else if (init_busy)
      begin
        init_cnt <= init_cnt + 1'b1;
        if (init_cnt == ($bits(init_cnt))'(INIT_CYC - 1))
          init_busy <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_ack_o <= 1'b0;
      engine_word_o <= 32'h0000_0000;
      engine_word_valid_o <= 1'b0;
      readback_ready_o <= 1'b0;
      master_clk_sel_o <= 1'b0;
      target_clk_sel_o <= 1'b0;
      pci_clk_to_grid_o <= 1'b0;
      source_o <= 2'h0;
      readback_mode_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cfg_ack_o <= cfg_wr_i || cfg_rd_i;
      cfg_rdata_o <= cfg_rd_i ? rd_mux : 32'h0000_0000;
      engine_word_o <= shift_load ? fifo_out_data : shift_reg;
      engine_word_valid_o <= !prog_pulse && (shift_load || (shift_full && !shift_take));
      readback_ready_o <= !readback_n && pci_owns && !sr_full && !rb_take;
      master_clk_sel_o <= master_clk_sel_i;
      target_clk_sel_o <= quad_port_i ? target_clk_sel_i : master_clk_sel_i;
      pci_clk_to_grid_o <= 1'b1;
      source_o <= next_src;
      readback_mode_o <= !readback_n;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  valid_set_a: assert property (data_wr && !prog_pulse |=> data_valid)
    else $error("valid flag not set by data write");
  valid_clear_a: assert property (ce_i && push_word && !data_wr && !prog_pulse
    |=> !data_valid && sr_empty)
    else $error("transfer did not clear valid and set empty");
  access_bit_a: assert property (jtag_busy |-> !csr_val[pcfgl_pkg::BIT_ACCESS_OK])
    else $error("access bit high during boundary scan");
  done_bit_a: assert property (csr_val[pcfgl_pkg::BIT_DONE] == engine_done_i)
    else $error("done bit does not follow engine");
  jtag_over_pci_a: assert property (ce_i && jtag_busy && !prog_pulse
    |=> src == pcfgl_pkg::SRC_JTAG)
    else $error("boundary scan did not take priority");
  pci_over_strap_a: assert property (ce_i && pci_req && strap_load && !jtag_busy && !prog_pulse
    |=> src == pcfgl_pkg::SRC_PCI)
    else $error("PCI load did not override strap load");
  session_start_a: assert property (csr_wr && cfg_wdata_i[pcfgl_pkg::BIT_LOAD_EN]
    |=> load_en)
    else $error("load enable not stored");
  readback_full_a: assert property (ce_i && rb_take && !readback_n && !prog_pulse
    |=> sr_full && data_word == $past(readback_word_i))
    else $error("readback word not captured");
  readback_mode_a: assert property (csr_wr && !cfg_wdata_i[pcfgl_pkg::BIT_READBACK_N]
    |=> !readback_n ##1 readback_mode_o || !ce_i)
    else $error("readback mode not entered");
  grid_clock_a: assert property (ce_i |=> pci_clk_to_grid_o)
    else $error("PCI clock not routed");
  dual_port_a: assert property (ce_i && !quad_port_i
    |=> target_clk_sel_o == master_clk_sel_o)
    else $error("dual-port clocks differ");
  engine_hold_a: assert property (ce_i && engine_word_valid_o && !engine_word_ready_i
    && !prog_pulse |=> engine_word_valid_o && $stable(engine_word_o))
    else $error("engine word dropped while stalled");
  ack_pulse_a: assert property (ce_i && (cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("access not acknowledged");
  full_clear_a: assert property (data_rd && !rb_take && !readback_n && !prog_pulse
    |=> !sr_full)
    else $error("full flag not cleared by data read");
  rb_once_a: assert property (ce_i && rb_take |=> !readback_ready_o)
    else $error("readback ready held after capture");
  load_cov: cover property (pci_owns && data_wr ##[1:20] push_word);
  rb_cov: cover property (rb_take ##[1:20] data_rd);
  jtag_cov: cover property (pci_owns ##1 jtag_busy);
  init_cov: cover property (prog_pulse ##1 !prog_pulse ##[1:20] init_busy);
  close_cov: cover property (readback_mode_o ##1 !readback_mode_o);
endmodule

// ### verif/pcfgl_engine_model.sv
// Configuration engine model: takes load words, offers readback words
`timescale 1ns/1ps
module pcfgl_engine_model #(
  parameter int DONE_AT = 18
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic stall_i,
  // Load stream
  input wire logic [31:0] word_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  output logic done_o,
  output logic init_n_o,
  // Readback stream
  input wire logic rb_ready_i,
  output logic [31:0] rb_word_o,
  output logic rb_valid_o
);
  logic [31:0] got [0:31];
  int n_got;
  int n_rb;
  // ----------------------------------------
  // Load side
  // ----------------------------------------
  // Stall lets the bench back the pipe up into the loader
  assign word_ready_o = !stall_i;
  assign done_o = (n_got >= DONE_AT);
  assign init_n_o = 1'b1;
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      n_got <= 0;
      n_rb <= 0;
    end
    else
    begin
      if (word_valid_i && word_ready_o && n_got < 32)
      begin
        got[n_got] <= word_i;
        n_got <= n_got + 1;
      end
      if (rb_valid_o && rb_ready_i)
        n_rb <= n_rb + 1;
    end
  end
  // ----------------------------------------
  // Readback side
  // ----------------------------------------
  assign rb_valid_o = !srst_i;
  assign rb_word_o = 32'hC0DE_0000 + n_rb;
endmodule

// ### verif/pcfgl_loader_bench.sv
// Self-checking bench for the PCI configuration loader
`timescale 1ns/1ps
module pcfgl_loader_bench;
  logic clk_i, srst_i, wr, rd, ack, prog_n, jtag, strap_ld, quad, msel, tsel;
  logic msel_o, tsel_o, grid, rbm, stall, ewv, ewr, done, initn, rbv, rbr;
  logic [7:0] addr;
  logic [3:0] be;
  logic [2:0] strap_m;
  logic [1:0] src;
  logic [31:0] wdata, rdata, ew, rbw, q;
  int n_errors, n_tests, i, k, acc;
  pcfgl_loader #(.INIT_CYC(4), .DEPTH(16)) pcfgl_loader_i (.clk_i(clk_i), .srst_i(srst_i),
    .ce_i(1'b1), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack), .program_pin_n_i(prog_n),
    .jtag_busy_i(jtag), .strap_load_i(strap_ld), .strap_mode_pins_i(strap_m),
    .engine_word_o(ew), .engine_word_valid_o(ewv), .engine_word_ready_i(ewr),
    .engine_done_i(done), .engine_init_n_i(initn), .readback_word_i(rbw),
    .readback_valid_i(rbv), .readback_ready_o(rbr), .quad_port_i(quad),
    .master_clk_sel_i(msel), .target_clk_sel_i(tsel), .master_clk_sel_o(msel_o),
    .target_clk_sel_o(tsel_o), .pci_clk_to_grid_o(grid), .source_o(src),
    .readback_mode_o(rbm));
  pcfgl_engine_model #(.DONE_AT(18)) pcfgl_engine_model_i (.clk_i(clk_i), .srst_i(srst_i),
    .stall_i(stall), .word_i(ew), .word_valid_i(ewv), .word_ready_o(ewr), .done_o(done),
    .init_n_o(initn), .rb_ready_i(rbr), .rb_word_o(rbw), .rb_valid_o(rbv));
  always #50 clk_i = ~clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up(input string what);
    n_errors++;
    $display("[ERR] %s expected response seen none", what);
    tally_and_finish();
  endtask
  // One strobe cycle, then a bounded wait for the ack
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] r);
    @(negedge clk_i);
    wr = w;
    rd = !w;
    addr = a;
    be = b;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
    rd = 1'b0;
    // Ack stands one cycle only: look before waiting further
    for (int n = 0; n < 4 && ack !== 1'b1; n++)
      @(negedge clk_i);
    if (ack !== 1'b1)
      give_up("ack");
    r = rdata;
  endtask
  task automatic csr_wr(input logic [15:0] v);
    access(1'b1, pcfgl_pkg::CSR_OFFSET, 4'hF, {16'h0000, v}, q);
  endtask
  task automatic csr_rd();
    access(1'b0, pcfgl_pkg::CSR_OFFSET, 4'hF, 32'h0000_0000, q);
  endtask
  task automatic data_wr(input logic [31:0] v);
    access(1'b1, pcfgl_pkg::DATA_OFFSET, 4'hF, v, q);
  endtask
  task automatic poll(input logic [31:0] mask, input logic [31:0] exp, input string what);
    for (int n = 0; n < 40; n++)
    begin
      csr_rd();
      if ((q & mask) === exp)
        return;
    end
    give_up(what);
  endtask
  function automatic logic [31:0] word(input int n);
    return (n == 0) ? 32'hFFFF_FFFF : 32'hA500_0000 + n;
  endfunction
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {clk_i, wr, rd, jtag, strap_ld, quad, msel, tsel, addr, be, wdata} = '0;
    {srst_i, prog_n, stall, strap_m} = 6'h3F;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    csr_rd();
    check("csr_reset", q & 32'h0000_0703, 32'h0000_0501);
    access(1'b0, 8'h48, 4'hF, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    check("grid", {31'h0, grid}, 32'h1);
    msel = 1'b1;
    repeat (3) @(negedge clk_i);
    check("tsel_dual", {31'h0, tsel_o}, 32'h1);
    quad = 1'b1;
    repeat (3) @(negedge clk_i);
    check("tsel_quad", {30'h0, msel_o, tsel_o}, 32'h2);
    jtag = 1'b1;
    repeat (4) @(negedge clk_i);
    csr_rd();
    check("access_ok", q & 32'h1, 32'h0);
    check("src_jtag", {30'h0, src}, 32'h3);
    jtag = 1'b0;
    strap_m = 3'h0;
    strap_ld = 1'b1;
    poll(32'h1, 32'h1, "access_ok");
    check("src_strap", {30'h0, src}, 32'h1);
    csr_wr(16'h0500);
    csr_wr(16'h0400);
    csr_wr(16'h0500);
    csr_wr(16'h0700);
    repeat (2) @(negedge clk_i);
    check("src_pci", {30'h0, src}, 32'h2);
    poll(32'h4, 32'h4, "init_n");
    // settle time before the ones word
    repeat (15000) @(negedge clk_i);
    acc = 0;
    for (i = 0; i < 20; i++)
    begin
      data_wr(word(i));
      // next word only once this one moved on
      for (k = 0; k < 6; k++)
      begin
        csr_rd();
        if (q[3] === 1'b0)
          break;
      end
      if (q[3] !== 1'b0)
        break;
      acc++;
    end
    // Stalled engine: FIFO plus shift stage hold the rest
    check("accepted", acc, 32'd17);
    check("pending", q & 32'h1E, 32'h0C);
    access(1'b1, pcfgl_pkg::DATA_OFFSET, 4'h3, 32'h0000_0000, q);
    access(1'b0, pcfgl_pkg::DATA_OFFSET, 4'hF, 32'h0000_0000, q);
    check("part_write", q, word(17));
    @(negedge clk_i);
    stall = 1'b0;
    poll(32'h18, 32'h10, "drained");
    for (k = 0; k < 200 && pcfgl_engine_model_i.n_got < 18; k++)
      @(negedge clk_i);
    if (pcfgl_engine_model_i.n_got < 18)
      give_up("engine_words");
    for (i = 0; i < 18; i++)
      check("engine_word", pcfgl_engine_model_i.got[i], word(i));
    csr_rd();
    check("done", q & 32'h2, 32'h2);
    csr_wr(16'h0500);
    prog_n = 1'b0;
    repeat (4) @(negedge clk_i);
    check("src_pin", {30'h0, src}, 32'h0);
    csr_rd();
    check("init_pin", q & 32'h4, 32'h0);
    prog_n = 1'b1;
    strap_ld = 1'b0;
    csr_wr(16'h0300);
    repeat (2) @(negedge clk_i);
    check("rb_mode", {31'h0, rbm}, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      poll(32'h20, 32'h20, "full");
      access(1'b0, pcfgl_pkg::DATA_OFFSET, 4'hF, 32'h0000_0000, q);
      check("rb_word", q, 32'hC0DE_0000 + i);
    end
    csr_wr(16'h0700);
    data_wr(32'hFFFF_FFFF);
    poll(32'h18, 32'h10, "rb_close");
    csr_wr(16'h0500);
    check("rb_off", {31'h0, rbm}, 32'h0);
    tally_and_finish();
  end
endmodule
